// >>> include/src_consts.vh
/*
 * Constants for the system reset controller: register map of the AXI4-Lite
 * slave, field positions, reset values, timing figures and derived counts.
 * Assumes a 25 MHz system clock; included by bare name from hdl/ files.
 */
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH

// Register byte offsets.
`define SRC_OFF_CAUSE      4'h0
`define SRC_OFF_CTRL       4'h4
`define SRC_OFF_OSC        4'h8
`define SRC_OFF_STATUS     4'hc

// Cause register fields.
`define SRC_CAUSE_POR      0
`define SRC_CAUSE_EXT      1
`define SRC_CAUSE_WDOG     2
`define SRC_CAUSE_DROOP    3
`define SRC_CAUSE_STOP     4
`define SRC_CAUSE_W        5

// Control register fields.
`define SRC_CTRL_DBGRST    0
`define SRC_CTRL_XTAL      1
`define SRC_CTRL_GPIOIND   2
`define SRC_CTRL_W         3

// Oscillator control fields.
`define SRC_OSC_RCEN       0
`define SRC_OSC_SEL_LSB    1
`define SRC_OSC_SEL_MSB    2
`define SRC_OSC_W          3
`define SRC_OSC_RESET      3'h1
`define SRC_OSC_RC_SEL     2'h0

// Minimum pin low width that always resets, in cycles.
`define SRC_PIN_MIN_LOW    3'h4
`define SRC_PIN_CNT_W      3

// Stop recovery holds, in internal RC oscillator cycles.
`define SRC_STOP_RC_CYC    66
`define SRC_STOP_XTAL_CYC  5000

// Default system reset time-out and indicator delay, in cycles.
`define SRC_SYS_TIMEOUT    16
`define SRC_IND_DELAY      16
`define SRC_CNT_W          16

`endif

// >>> hdl/src_hold_counter.v
/*
 * Down counter that holds a "busy" level for a loaded number of cycles.
 * Assumes a single synchronous clock and an active-low synchronous reset.
 */
`timescale 1ns/1ns
`include "src_consts.vh"

module src_hold_counter (
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire                   load,
   input  wire [`SRC_CNT_W-1:0]  count,
   output wire                   busy
);

   reg [`SRC_CNT_W-1:0] cnt_q;

   // A load restarts the count even while busy, so a new event stretches the hold.
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= {`SRC_CNT_W{1'b0}};
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != {`SRC_CNT_W{1'b0}}) begin
         cnt_q <= cnt_q - {{(`SRC_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign busy = (cnt_q != {`SRC_CNT_W{1'b0}});

endmodule // src_hold_counter

// >>> hdl/src_reset_ctrl.v
/*
 * System reset controller: merges pin, power-on, watchdog, supply droop,
 * stop-exit and debug reset requests, holds the core in reset, records the
 * cause, drives the open-drain reset pin, and forces the RC oscillator after
 * stop recovery. Registers sit behind an AXI4-Lite slave.
 * Assumes all inputs are synchronous to aclk (25 MHz) and that aresetn is
 * only the bus/fabric reset, not itself a documented reset source.
 */
`timescale 1ns/1ns
`include "src_consts.vh"

// How it works
// - Pin, power-on, watchdog, stop exit and droop each start a reset.
// - Core reset stays asserted while the pin input is low.
// - After a long pin hold, reset ends on the edge after pin release.
// - A pin-caused reset sets the external reset flag.
// - Pin is driven low open-drain during internal resets or when GPIO enables it.
// - Internal resets drive the pin low until the indicator delay ends.
// - Debug reset request starts a power-on style reset, sparing debug logic.
// - The debug reset request bit clears itself during its reset.
// - A debug-started reset sets the power-on flag.
// - Stop instruction enters the stop state.
// - Stop recovery holds reset 66 or 5000 cycles by crystal enable.
// - Stop recovery changes only cause and oscillator registers.
// - Stop recovery enables and selects the internal RC oscillator.
module src_reset_ctrl #(
   parameter [`SRC_CNT_W-1:0] SYS_TIMEOUT = `SRC_SYS_TIMEOUT,
   parameter [`SRC_CNT_W-1:0] IND_DELAY   = `SRC_IND_DELAY,
   parameter [`SRC_CNT_W-1:0] STOP_XTAL   = `SRC_STOP_XTAL_CYC
) (
   input  wire                    aclk,
   input  wire                    aresetn,
   // AXI4-Lite slave.
   input  wire [3:0]              s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output wire                    s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output wire                    s_axi_wready,
   output wire [1:0]              s_axi_bresp,
   output wire                    s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [3:0]              s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output wire                    s_axi_arready,
   output wire [31:0]             s_axi_rdata,
   output wire [1:0]              s_axi_rresp,
   output wire                    s_axi_rvalid,
   input  wire                    s_axi_rready,
   // Reset sources.
   input  wire                    reset_pin_n_i,
   output wire                    reset_pin_n_o,
   output wire                    reset_pin_n_oe,
   input  wire                    power_on_reset,
   input  wire                    watchdog_timeout,
   input  wire                    supply_droop_detect,
   input  wire                    stop_instr,
   input  wire                    stop_wakeup,
   // Reset outputs.
   output wire                    core_reset,
   output wire                    debug_unit_reset,
   output wire                    stop_active,
   output wire [`SRC_OSC_W-1:0]   osc_ctrl
);

   localparam [`SRC_CNT_W-1:0] STOP_RC = `SRC_STOP_RC_CYC;

   // One-hot states of the reset sequencer.
   localparam [3:0] ST_RUN  = 4'h1;
   localparam [3:0] ST_HOLD = 4'h2;
   localparam [3:0] ST_STOP = 4'h4;
   localparam [3:0] ST_SREC = 4'h8;

   reg [3:0]                  state_q;
   reg [3:0]                  state_d;
   reg [`SRC_CAUSE_W-1:0]     cause_q;
   reg [`SRC_CTRL_W-1:0]      ctrl_q;
   reg [`SRC_OSC_W-1:0]       osc_q;
   reg [`SRC_PIN_CNT_W-1:0]   pin_low_q;
   reg                        ind_q;
   reg                        por_q;

   wire pin_low   = ~reset_pin_n_i;
   // Gating with the live level ends a pin request in the very cycle the pin is released.
   wire pin_req   = pin_low & (pin_low_q >= `SRC_PIN_MIN_LOW);
   wire dbg_req   = ctrl_q[`SRC_CTRL_DBGRST];
   wire int_req   = power_on_reset | watchdog_timeout | supply_droop_detect | dbg_req;
   // The indicator drives the pin low, so the indicator's own drive must not count as a pin request.
   wire ext_req   = pin_req & ~ind_q;
   wire any_req   = int_req | ext_req;
   wire tmo_busy;
   wire ind_busy;
   wire srec_busy;
   // A pin held low must not keep reloading the time-out, or its release would exit late.
   wire tmo_load  = int_req | (ext_req & (state_q != ST_HOLD));
   wire ind_load  = int_req;
   wire srec_load = (state_q == ST_STOP) & stop_wakeup;
   wire [`SRC_CNT_W-1:0] srec_cnt = ctrl_q[`SRC_CTRL_XTAL] ? STOP_XTAL : STOP_RC;

   // Time-out counter; its length is a parameter since no figure is fixed.
   src_hold_counter u_tmo (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (tmo_load),
      .count   (SYS_TIMEOUT),
      .busy    (tmo_busy)
   );

   // Reset indicator delay counter.
   src_hold_counter u_ind (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (ind_load),
      .count   (IND_DELAY),
      .busy    (ind_busy)
   );

   // Stop recovery hold counter.
   src_hold_counter u_srec (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (srec_load),
      .count   (srec_cnt),
      .busy    (srec_busy)
   );

   // Counts consecutive low cycles on the pin, saturating at the threshold.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_low_q <= {`SRC_PIN_CNT_W{1'b0}};
      end else if (!pin_low) begin
         pin_low_q <= {`SRC_PIN_CNT_W{1'b0}};
      end else if (!pin_req) begin
         pin_low_q <= pin_low_q + {{(`SRC_PIN_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Sequencer next state.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (any_req) begin
               state_d = ST_HOLD;
            end else if (stop_instr) begin
               state_d = ST_STOP;
            end
         end
         ST_HOLD: begin
            // Stay while the pin is low or the time-out runs; exit on the next edge.
            if (!any_req && !tmo_busy && !pin_low) begin
               state_d = ST_RUN;
            end
         end
         ST_STOP: begin
            if (any_req) begin
               state_d = ST_HOLD;
            end else if (stop_wakeup) begin
               state_d = ST_SREC;
            end
         end
         ST_SREC: begin
            if (any_req) begin
               state_d = ST_HOLD;
            end else if (!srec_busy) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_HOLD;
         end
      endcase
   end

   // State register; fabric reset lands in the hold state like a power-on.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_HOLD;
         ind_q   <= 1'b0;
         por_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         ind_q   <= (state_d == ST_HOLD) & (ind_load | ind_busy | int_req);
         por_q   <= 1'b0;
      end
   end

   // AXI4-Lite slave: one write and one read outstanding, address and data in any order.
   reg        aw_q;
   reg        w_q;
   reg [3:0]  awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   reg        bvalid_q;
   reg [1:0]  bresp_q;
   reg        rvalid_q;
   reg [1:0]  rresp_q;
   reg [31:0] rdata_q;
   reg [31:0] rd_val;
   reg        rd_ok;

   assign s_axi_awready = ~aw_q & ~bvalid_q;
   assign s_axi_wready  = ~w_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   wire do_wr  = aw_q & w_q & ~bvalid_q;
   wire wr_ok  = (awaddr_q == `SRC_OFF_CAUSE) | (awaddr_q == `SRC_OFF_CTRL) |
                 (awaddr_q == `SRC_OFF_OSC);
   wire wr_ctl = do_wr & (awaddr_q == `SRC_OFF_CTRL) & wstrb_q[0];
   wire wr_osc = do_wr & (awaddr_q == `SRC_OFF_OSC) & wstrb_q[0];
   wire wr_cau = do_wr & (awaddr_q == `SRC_OFF_CAUSE) & wstrb_q[0];

   // Read mux; unmapped offsets answer SLVERR with zero data.
   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         `SRC_OFF_CAUSE:  rd_val[`SRC_CAUSE_W-1:0] = cause_q;
         `SRC_OFF_CTRL:   rd_val[`SRC_CTRL_W-1:0]  = ctrl_q;
         `SRC_OFF_OSC:    rd_val[`SRC_OSC_W-1:0]   = osc_q;
         `SRC_OFF_STATUS: rd_val[3:0]              = state_q;
         default:         rd_ok = 1'b0;
      endcase
   end

   // Bus channel handshakes.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
         rvalid_q <= 1'b0;
         rresp_q  <= 2'h0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? 2'h0 : 2'h2;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_ok ? 2'h0 : 2'h2;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Control register. The debug request clears itself once its reset is under way;
   // the clear comes from the hold state, so a fresh write wins over it.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= {`SRC_CTRL_W{1'b0}};
      end else if (wr_ctl) begin
         ctrl_q <= wdata_q[`SRC_CTRL_W-1:0];
      end else if (state_q == ST_HOLD) begin
         ctrl_q[`SRC_CTRL_DBGRST] <= 1'b0;
      end
   end

   // Cause flags: hardware sets win over a software clear (write one to clear).
   always @(posedge aclk) begin
      if (!aresetn) begin
         cause_q <= {`SRC_CAUSE_W{1'b0}} | (1'b1 << `SRC_CAUSE_POR);
      end else begin
         if (wr_cau) begin
            cause_q <= cause_q & ~wdata_q[`SRC_CAUSE_W-1:0];
         end
         if (power_on_reset | dbg_req) begin
            cause_q[`SRC_CAUSE_POR] <= 1'b1;
         end
         if (ext_req) begin
            cause_q[`SRC_CAUSE_EXT] <= 1'b1;
         end
         if (watchdog_timeout) begin
            cause_q[`SRC_CAUSE_WDOG] <= 1'b1;
         end
         if (supply_droop_detect) begin
            cause_q[`SRC_CAUSE_DROOP] <= 1'b1;
         end
         if (srec_load) begin
            cause_q[`SRC_CAUSE_STOP] <= 1'b1;
         end
      end
   end

   // Oscillator control: stop recovery forces the RC oscillator on and selected.
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_q <= `SRC_OSC_RESET;
      end else if (srec_load) begin
         osc_q[`SRC_OSC_RCEN] <= 1'b1;
         osc_q[`SRC_OSC_SEL_MSB:`SRC_OSC_SEL_LSB] <= `SRC_OSC_RC_SEL;
      end else if (wr_osc) begin
         osc_q <= wdata_q[`SRC_OSC_W-1:0];
      end
   end

   // Core reset covers hold and stop recovery; the debug unit sees only power-on.
   assign core_reset       = (state_q == ST_HOLD) | (state_q == ST_SREC) | pin_low;
   assign debug_unit_reset = power_on_reset | por_q;
   assign stop_active      = (state_q == ST_STOP);
   assign osc_ctrl         = osc_q;

   // Open-drain pin: output value is always low, enable selects drive.
   assign reset_pin_n_o  = 1'b0;
   assign reset_pin_n_oe = ind_q | ctrl_q[`SRC_CTRL_GPIOIND];

endmodule // src_reset_ctrl

// >>> bench/src_board_model.sv
/* Board side of the reset pin: a pull-up and a push button.
   Assumes the device's open-drain enable and value at its pin. */
`timescale 1ns/1ns
module src_board_model (
   input  wire logic aclk,
   input  wire logic dev_oe,
   input  wire logic dev_o,
   output wire logic pin_level
);
   logic press_q = 1'b0;
   // The pull-up wins only when no party pulls the wire down.
   assign pin_level = press_q ? 1'b0 : (dev_oe ? dev_o : 1'b1);
   // A press never falls short of the width that always resets.
   task automatic hold_low(input int n);
      @(posedge aclk);
      press_q <= 1'b1;
      repeat ((n < 4) ? 4 : n) @(posedge aclk);
      press_q <= 1'b0;
   endtask
endmodule // src_board_model

// >>> bench/src_reset_ctrl_asserts.sv
/* Port checks for the reset controller.
   Assumes binding onto src_reset_ctrl with its own parameters. */
`timescale 1ns/1ns
module src_reset_ctrl_chk #(
   parameter int SYS_TIMEOUT = 16,
   parameter int IND_DELAY   = 16,
   parameter int STOP_XTAL   = 5000
) (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       reset_pin_n_i,
   input wire logic       reset_pin_n_oe,
   input wire logic       power_on_reset,
   input wire logic       watchdog_timeout,
   input wire logic       stop_instr,
   input wire logic       core_reset,
   input wire logic       debug_unit_reset,
   input wire logic       stop_active,
   input wire logic [2:0] osc_ctrl
);
   int   low_q, oe_q, rec_q;
   logic in_rec_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Run lengths: low pin, indicator in reset, and a stop recovery hold.
   always @(posedge aclk) begin
      low_q    <= (!aresetn || reset_pin_n_i) ? 0 : low_q + 1;
      oe_q     <= (aresetn && reset_pin_n_oe && core_reset) ? oe_q + 1 : 0;
      rec_q    <= (aresetn && core_reset && !stop_active) ? rec_q + 1 : 0;
      in_rec_q <= !aresetn ? 1'b0 : stop_active ? 1'b1 : $fell(core_reset) ? 1'b0 : in_rec_q;
   end
   pin_hold_a: assert property (!reset_pin_n_i |-> core_reset)
      else $error("core runs while the pin is low");
   pin_exit_a: assert property ($rose(reset_pin_n_i) && low_q > SYS_TIMEOUT + 8 |-> core_reset ##1 !core_reset)
      else $error("late exit after a long pin hold");
   wdog_req_a: assert property ($rose(watchdog_timeout) |-> ##[1:2] core_reset)
      else $error("watchdog request did not reset the core");
   ind_drive_a: assert property ($rose(watchdog_timeout) && !core_reset |-> ##[1:2] reset_pin_n_oe)
      else $error("pin not driven after an internal reset");
   ind_len_a: assert property (oe_q <= IND_DELAY + 2)
      else $error("indicator held beyond its delay");
   stop_enter_a: assert property (stop_instr && !core_reset && !stop_active |=> stop_active)
      else $error("stop state not entered");
   stop_hold_a: assert property (in_rec_q && $fell(core_reset) |-> (rec_q >= 64 && rec_q <= 68) || (rec_q >= STOP_XTAL - 2 && rec_q <= STOP_XTAL + 2))
      else $error("stop recovery hold has the wrong length");
   stop_osc_a: assert property (in_rec_q && $fell(core_reset) |-> osc_ctrl == 3'h1)
      else $error("oscillator not forced to the rc source");
   dbg_spare_a: assert property (debug_unit_reset |-> power_on_reset || $past(power_on_reset) || !$past(aresetn))
      else $error("debug unit reset outside power-on");
   cover property (in_rec_q && $fell(core_reset));
   cover property ($rose(reset_pin_n_i) && low_q > SYS_TIMEOUT + 8);
   cover property ($rose(reset_pin_n_oe) && !stop_active);
endmodule // src_reset_ctrl_chk

bind src_reset_ctrl src_reset_ctrl_chk #(.SYS_TIMEOUT(SYS_TIMEOUT), .IND_DELAY(IND_DELAY),
   .STOP_XTAL(STOP_XTAL)) u_chk (.aclk, .aresetn, .reset_pin_n_i, .reset_pin_n_oe,
   .power_on_reset, .watchdog_timeout, .stop_instr, .core_reset, .debug_unit_reset,
   .stop_active, .osc_ctrl);

// >>> bench/test_system_reset_controller.sv
/* Self-checking bench for the reset controller and its registers.
   Assumes the board model and the bound checker are compiled first. */
`timescale 1ns/1ns
module test_system_reset_controller;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [4:0]  ev = 5'h0;
   logic [31:0] wdata = 32'h0, rd_q;
   logic [1:0]  rsp_q;
   wire         awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin;
   wire         core_reset, dbg_rst, stop_active;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [2:0]  osc_ctrl;
   int          num_errors = 0, checks_done = 0, wc = 0, dbg_seen = 0;
   // The 25 MHz clock.
   always #20 aclk = ~aclk;
   // Debug unit reset cycles, so a debug-started reset can be judged.
   always @(posedge aclk) if (dbg_rst) dbg_seen++;
   // Short counts keep the run brief; ev drives the five event inputs.
   src_reset_ctrl #(.SYS_TIMEOUT(16'd8), .IND_DELAY(16'd6), .STOP_XTAL(16'd20)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(addr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(addr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .reset_pin_n_i(pin), .reset_pin_n_o(pin_o), .reset_pin_n_oe(pin_oe),
      .power_on_reset(ev[0]), .watchdog_timeout(ev[1]), .supply_droop_detect(ev[2]),
      .stop_instr(ev[3]), .stop_wakeup(ev[4]), .core_reset(core_reset),
      .debug_unit_reset(dbg_rst), .stop_active(stop_active), .osc_ctrl(osc_ctrl));
   src_board_model board (.aclk(aclk), .dev_oe(pin_oe), .dev_o(pin_o), .pin_level(pin));

   task results;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Samples at the falling edge; a wait that runs too long ends the run.
   task step;
      @(negedge aclk);
      wc++;
      if (wc > 3000) begin
         num_errors++;
         results;
      end
   endtask
   // One bus transfer: readies are sampled mid-cycle, releases follow the edge.
   task axi(input logic we, input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, tr, fin;
      @(posedge aclk);
      addr <= a;
      wdata <= d;
      awvalid <= we;
      wvalid <= we;
      bready <= we;
      arvalid <= !we;
      rready <= !we;
      wc = 0;
      do begin
         step;
         ta = awready;
         tw = wready;
         tr = arready;
         fin = (bvalid && bready) || (rvalid && rready);
         rd_q = rdata;
         rsp_q = we ? bresp : rresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
      end while (!fin);
      bready <= 1'b0;
      rready <= 1'b0;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      axi(1'b1, a, d);
   endtask
   task rdc(input logic [3:0] a, input logic [31:0] e);
      axi(1'b0, a, 32'h0);
      chk(rd_q, e);
   endtask
   task wait_core(input logic v);
      wc = 0;
      do step; while (core_reset !== v);
   endtask
   task pulse(input int i);
      @(posedge aclk);
      ev[i] <= 1'b1;
      @(posedge aclk);
      ev[i] <= 1'b0;
   endtask
   task t_regs;
      rdc(4'h0, 32'h1);
      rdc(4'h8, 32'h1);
      rdc(4'hc, 32'h1);
      rdc(4'h2, 32'h0);
      chk(rsp_q, 32'h2);
      wr(4'hc, 32'h0);
      chk(rsp_q, 32'h2);
      wr(4'h0, 32'h1f);
      chk(rsp_q, 32'h0);
   endtask
   task t_pin;
      fork
         board.hold_low(30);
      join_none
      wc = 0;
      repeat (10) step;
      chk(core_reset, 1'b1);
      do step; while (pin !== 1'b1);
      step;
      chk(core_reset, 1'b0);
      rdc(4'h0, 32'h2);
   endtask
   task t_internal;
      int i;
      for (i = 0; i < 3; i++) begin
         wr(4'h0, 32'h1f);
         pulse(i);
         wc = 0;
         do step; while (pin_oe !== 1'b1);
         chk(pin, 1'b0);
         wait_core(1'b0);
         chk(pin, 1'b1);
         rdc(4'h0, (i == 0) ? 32'h1 : 32'h4 << (i - 1));
      end
   endtask
   task t_debug;
      wr(4'h0, 32'h1f);
      dbg_seen = 0;
      wr(4'h4, 32'h1);
      wait_core(1'b1);
      wait_core(1'b0);
      chk(dbg_seen, 32'h0);
      rdc(4'h4, 32'h0);
      rdc(4'h0, 32'h1);
   endtask
   // Crystal first, so the short hold is seen before the long one.
   task t_stop;
      int x, n, e;
      for (x = 1; x >= 0; x--) begin
         e = x ? 20 : 66;
         wr(4'h0, 32'h1f);
         wr(4'h8, 32'h6);
         wr(4'h4, x * 2);
         pulse(3);
         step;
         chk(stop_active, 1'b1);
         pulse(4);
         wait_core(1'b1);
         n = 0;
         do begin
            n++;
            step;
         end while (core_reset === 1'b1 && n < 200);
         chk(n + 2 >= e && n <= e + 2, 1'b1);
         rdc(4'h8, 32'h1);
         rdc(4'h0, 32'h10);
         rdc(4'h4, x * 2);
      end
   endtask
   task t_gpio;
      wr(4'h4, 32'h4);
      step;
      chk(pin, 1'b0);
      wr(4'h4, 32'h0);
      step;
      chk(pin, 1'b1);
   endtask
   // Reset for five cycles, then the scenarios in turn.
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_pin;
      t_internal;
      t_debug;
      t_stop;
      t_gpio;
      results;
   end
endmodule // test_system_reset_controller
